// [src/cpu_bus_cycle_addressing.v]
// bus-cycle sequencer: one classified system-bus cycle per bus clock, operand fetch and address forming
`timescale 1ns/1ps
`include "cpu_bus_regs.vh"

// Notes on behaviour
// - A free cycle uses no bus data and lasts exactly one bus clock period.
// - A free cycle is shown on the bus as a read, never a write.
// - A program fetch reads the location the program counter points to, then advances the counter by one.
// - An operand read moves exactly one byte from the addressed location.
// - An operand write stores exactly one byte to the addressed location.
// - A push writes one byte at the stack location.
// - A pop reads one byte from the stack location.
// - Vector fetches read from the top page, high byte before low byte.
// - An operand field is zero, one or two bytes of the instruction stream, set by the mode.
// - The pc-relative form carries one offset byte applied to the program counter.
// - Short indexed mode adds an 8-bit offset to the index register.
// - Long indexed mode adds a 16-bit offset to the index register.
// - Post-increment indexed mode addresses the index register, then increments it.
// - Post-increment mode with byte offset addresses index plus offset, then increments the index.
// - Stack short mode addresses stack pointer plus an 8-bit offset.
// - Stack long mode addresses stack pointer plus a 16-bit offset.
module cpu_bus_cycle_addressing (
  input  wire        clk,
  input  wire        rst_n,
  input  wire        cmd_valid,
  output wire        cmd_ready,
  input  wire [2:0]  cmd_kind,
  input  wire [3:0]  cmd_mode,
  input  wire [7:0]  cmd_wdata,
  input  wire [7:0]  cmd_vector,
  input  wire        cmd_take,
  input  wire        pc_load,
  input  wire [15:0] pc_load_val,
  input  wire        sp_load,
  input  wire [15:0] sp_load_val,
  input  wire        hx_load,
  input  wire [15:0] hx_load_val,
  output reg         rsp_valid,
  output reg  [7:0]  rsp_data,
  output reg  [15:0] bus_addr,
  output reg  [7:0]  bus_wdata,
  output reg         bus_rd,
  output reg         bus_wr,
  input  wire [7:0]  bus_rdata,
  output reg  [2:0]  bus_cycle,
  output reg  [15:0] prog_counter,
  output reg  [15:0] stack_ptr,
  output reg  [15:0] index_reg
);

  // ****************************************************************
  // states, one-hot, each naming the cycle now on the bus
  // ****************************************************************
  localparam [6:0] S_FREE   = 7'h01;
  localparam [6:0] S_FETCH1 = 7'h02;
  localparam [6:0] S_FETCH2 = 7'h04;
  localparam [6:0] S_ACCESS = 7'h08;
  localparam [6:0] S_VECH   = 7'h10;
  localparam [6:0] S_VECL   = 7'h20;
  localparam [6:0] S_STACK  = 7'h40;

  localparam integer      DIV_LAST_I = `BUS_DIV - 1;
  localparam [`DIV_W-1:0] DIV_LAST   = DIV_LAST_I[`DIV_W-1:0];

  // operand bytes carried in the instruction stream per mode
  function [1:0] op_bytes;
    input [3:0] m;
    begin
      case (m)
        `MODE_DIRECT,
        `MODE_INDEX_SHORT_DISP,
        `MODE_INDEX_DISP_POSTINC,
        `MODE_STACK_SHORT_DISP:   op_bytes = 2'd1;
        `MODE_EXTENDED,
        `MODE_INDEX_LONG_DISP,
        `MODE_STACK_LONG_DISP:    op_bytes = 2'd2;
        default:                  op_bytes = 2'd0;
      endcase
    end
  endfunction

  // ****************************************************************
  // declarations
  // ****************************************************************
  reg  [`DIV_W-1:0] div_r;
  reg  [6:0]        state_r;
  reg  [6:0]        state_nxt;
  reg  [2:0]        kind_r;
  reg  [2:0]        kind_nxt;
  reg  [3:0]        mode_r;
  reg  [3:0]        mode_nxt;
  reg  [7:0]        wd_r;
  reg  [7:0]        wd_nxt;
  reg  [7:0]        vec_r;
  reg  [7:0]        vec_nxt;
  reg               take_r;
  reg               take_nxt;
  reg  [15:0]       disp_r;
  reg  [15:0]       disp_nxt;
  reg  [15:0]       pc_nxt;
  reg  [15:0]       sp_nxt;
  reg  [15:0]       hx_nxt;
  reg  [15:0]       addr_nxt;
  reg  [7:0]        wdata_nxt;
  reg               rd_nxt;
  reg               wr_nxt;
  reg  [2:0]        cyc_nxt;
  reg               rsp_nxt;
  reg  [7:0]        rdat_nxt;
  reg               acc_go;
  wire              bus_tick;
  wire              done;
  wire [3:0]        fmode;
  wire [15:0]       disp_in;
  wire [15:0]       ea;
  wire              post_inc;
  wire [15:0]       pc_fin;

  // ****************************************************************
  // bus clock enable
  // ****************************************************************
  // one pulse per bus period; every cycle decision is taken on it only
  assign bus_tick = (div_r == DIV_LAST);

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_r <= {`DIV_W{1'b0}};
    end else if (bus_tick) begin
      div_r <= {`DIV_W{1'b0}};
    end else begin
      div_r <= div_r + 1'b1;
    end
  end

  // ****************************************************************
  // command boundary and address former inputs
  // ****************************************************************
  // the cycle on the bus is the last one of its command
  assign done = bus_tick &
                ((state_r == S_FREE) | (state_r == S_ACCESS) | (state_r == S_VECL) |
                 (state_r == S_STACK) |
                 ((state_r == S_FETCH1) & ((kind_r == `KIND_PROG) | (kind_r == `KIND_BRANCH))));

  assign cmd_ready = done;

  // a command with no operand bytes goes straight to its access, so the
  // former must see the incoming mode in that tick
  assign fmode   = done ? cmd_mode : mode_r;
  assign disp_in = (state_r == S_FETCH2) ? {disp_r[15:8], bus_rdata} :
                   (state_r == S_FETCH1) ? {8'h00, bus_rdata} : 16'h0000;

  // pc once the finishing cycle lands; a command launched in that tick starts from it
  assign pc_fin = (state_r == S_VECL) ? {disp_r[15:8], bus_rdata} :
                  ((state_r == S_FETCH1) & (kind_r == `KIND_BRANCH) & take_r) ?
                  prog_counter + {{8{bus_rdata[7]}}, bus_rdata} : prog_counter;

  operand_addr_former u_former (
    .mode      (fmode),
    .index_val (index_reg),
    .stack_val (stack_ptr),
    .pc_val    (pc_fin),
    .disp      (disp_in),
    .ea        (ea),
    .post_inc  (post_inc)
  );

  // ****************************************************************
  // cycle sequencing
  // ****************************************************************
  // bus_rdata is sampled at the tick that ends the cycle, then the next
  // cycle is launched in the same tick so no bus period is lost
  always @* begin
    state_nxt = state_r;
    kind_nxt  = kind_r;
    mode_nxt  = mode_r;
    wd_nxt    = wd_r;
    vec_nxt   = vec_r;
    take_nxt  = take_r;
    disp_nxt  = disp_r;
    pc_nxt    = prog_counter;
    sp_nxt    = stack_ptr;
    hx_nxt    = index_reg;
    addr_nxt  = bus_addr;
    wdata_nxt = bus_wdata;
    rd_nxt    = bus_rd;
    wr_nxt    = bus_wr;
    cyc_nxt   = bus_cycle;
    rsp_nxt   = 1'b0;
    rdat_nxt  = rsp_data;
    acc_go    = 1'b0;
    if (bus_tick) begin
      // finish the cycle now on the bus
      case (state_r)
        S_FETCH1: begin
          if (kind_r == `KIND_PROG) begin
            rsp_nxt  = 1'b1;
            rdat_nxt = bus_rdata;
          end else if (kind_r == `KIND_BRANCH) begin
            // pc already points past the offset byte
            if (take_r) begin
              pc_nxt = pc_fin;
            end
          end else if (op_bytes(mode_r) == 2'd2) begin
            disp_nxt  = {bus_rdata, 8'h00};
            state_nxt = S_FETCH2;
            addr_nxt  = prog_counter;
            pc_nxt    = prog_counter + 16'h0001;
            rd_nxt    = 1'b1;
            wr_nxt    = 1'b0;
            cyc_nxt   = `KIND_PROG;
          end else begin
            acc_go = 1'b1;
          end
        end
        S_FETCH2: begin
          acc_go = 1'b1;
        end
        S_ACCESS: begin
          if (kind_r == `KIND_READ) begin
            rsp_nxt  = 1'b1;
            rdat_nxt = bus_rdata;
          end
        end
        S_VECH: begin
          disp_nxt  = {bus_rdata, 8'h00};
          state_nxt = S_VECL;
          addr_nxt  = {`VECTOR_PAGE, vec_r + 8'h01};
          rd_nxt    = 1'b1;
          wr_nxt    = 1'b0;
          cyc_nxt   = `KIND_VECTOR;
        end
        S_VECL: begin
          pc_nxt   = pc_fin;
          rsp_nxt  = 1'b1;
          rdat_nxt = bus_rdata;
        end
        S_STACK: begin
          if (kind_r == `KIND_POP) begin
            rsp_nxt  = 1'b1;
            rdat_nxt = bus_rdata;
          end
        end
        S_FREE: begin
          rsp_nxt = 1'b0;
        end
        default: begin
          state_nxt = S_FREE;
        end
      endcase

      // launch the next command, or a free cycle when none waits
      if (done) begin
        if (cmd_valid) begin
          kind_nxt = cmd_kind;
          mode_nxt = cmd_mode;
          wd_nxt   = cmd_wdata;
          vec_nxt  = cmd_vector;
          take_nxt = cmd_take;
          case (cmd_kind)
            `KIND_PROG,
            `KIND_BRANCH: begin
              state_nxt = S_FETCH1;
              addr_nxt  = pc_fin;
              pc_nxt    = pc_fin + 16'h0001;
              rd_nxt    = 1'b1;
              wr_nxt    = 1'b0;
              cyc_nxt   = `KIND_PROG;
            end
            `KIND_READ,
            `KIND_WRITE: begin
              if (op_bytes(cmd_mode) != 2'd0) begin
                state_nxt = S_FETCH1;
                addr_nxt  = pc_fin;
                pc_nxt    = pc_fin + 16'h0001;
                rd_nxt    = 1'b1;
                wr_nxt    = 1'b0;
                cyc_nxt   = `KIND_PROG;
              end else begin
                acc_go = 1'b1;
              end
            end
            `KIND_PUSH: begin
              state_nxt = S_STACK;
              addr_nxt  = stack_ptr;
              wdata_nxt = cmd_wdata;
              sp_nxt    = stack_ptr - 16'h0001;
              rd_nxt    = 1'b0;
              wr_nxt    = 1'b1;
              cyc_nxt   = `KIND_PUSH;
            end
            `KIND_POP: begin
              state_nxt = S_STACK;
              addr_nxt  = stack_ptr + 16'h0001;
              sp_nxt    = stack_ptr + 16'h0001;
              rd_nxt    = 1'b1;
              wr_nxt    = 1'b0;
              cyc_nxt   = `KIND_POP;
            end
            `KIND_VECTOR: begin
              state_nxt = S_VECH;
              addr_nxt  = {`VECTOR_PAGE, cmd_vector};
              rd_nxt    = 1'b1;
              wr_nxt    = 1'b0;
              cyc_nxt   = `KIND_VECTOR;
            end
            default: begin
              state_nxt = S_FREE;
              addr_nxt  = prog_counter;
              rd_nxt    = 1'b1;
              wr_nxt    = 1'b0;
              cyc_nxt   = `KIND_FREE;
            end
          endcase
        end else begin
          // an idle bus period is a free read, nothing is captured from it
          state_nxt = S_FREE;
          addr_nxt  = prog_counter;
          rd_nxt    = 1'b1;
          wr_nxt    = 1'b0;
          cyc_nxt   = `KIND_FREE;
        end
      end

      // the single operand access after its displacement is known
      if (acc_go) begin
        state_nxt = S_ACCESS;
        addr_nxt  = ea;
        wdata_nxt = wd_nxt;
        rd_nxt    = (kind_nxt != `KIND_WRITE);
        wr_nxt    = (kind_nxt == `KIND_WRITE);
        cyc_nxt   = (kind_nxt == `KIND_WRITE) ? `KIND_WRITE : `KIND_READ;
        if (post_inc) begin
          hx_nxt = index_reg + 16'h0001;
        end
        if (fmode == `MODE_IMMEDIATE) begin
          pc_nxt = pc_fin + 16'h0001;
        end
      end
    end

    // loads from the instruction unit take priority over sequencer updates
    if (pc_load) begin
      pc_nxt = pc_load_val;
    end
    if (sp_load) begin
      sp_nxt = sp_load_val;
    end
    if (hx_load) begin
      hx_nxt = hx_load_val;
    end
  end

  // ****************************************************************
  // state and bus registers
  // ****************************************************************
  // bus outputs change only on a tick, so each cycle holds one full period
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r      <= S_FREE;
      kind_r       <= `KIND_FREE;
      mode_r       <= `MODE_DIRECT;
      wd_r         <= 8'h00;
      vec_r        <= 8'h00;
      take_r       <= 1'b0;
      disp_r       <= 16'h0000;
      prog_counter <= `PC_RESET;
      stack_ptr    <= `SP_RESET;
      index_reg    <= `HX_RESET;
      bus_addr     <= `PC_RESET;
      bus_wdata    <= 8'h00;
      bus_rd       <= 1'b1;
      bus_wr       <= 1'b0;
      bus_cycle    <= `KIND_FREE;
      rsp_valid    <= 1'b0;
      rsp_data     <= 8'h00;
    end else begin
      state_r      <= state_nxt;
      kind_r       <= kind_nxt;
      mode_r       <= mode_nxt;
      wd_r         <= wd_nxt;
      vec_r        <= vec_nxt;
      take_r       <= take_nxt;
      disp_r       <= disp_nxt;
      prog_counter <= pc_nxt;
      stack_ptr    <= sp_nxt;
      index_reg    <= hx_nxt;
      bus_addr     <= addr_nxt;
      bus_wdata    <= wdata_nxt;
      bus_rd       <= rd_nxt;
      bus_wr       <= wr_nxt;
      bus_cycle    <= cyc_nxt;
      rsp_valid    <= rsp_nxt;
      rsp_data     <= rdat_nxt;
    end
  end

endmodule

// [src/cpu_bus_regs.vh]
// constants for the bus-cycle sequencer and the operand address former
`ifndef CPU_BUS_REGS_VH
`define CPU_BUS_REGS_VH

// ****************************************************************
// timing
// ****************************************************************
`define CLK_PERIOD_NS   10
`define BUS_PERIOD_NS   100
`define BUS_DIV         (`BUS_PERIOD_NS / `CLK_PERIOD_NS)
`define DIV_W           4

// ****************************************************************
// command and bus cycle kinds
// ****************************************************************
`define KIND_W          3
`define KIND_FREE       3'h0
`define KIND_PROG       3'h1
`define KIND_READ       3'h2
`define KIND_WRITE      3'h3
`define KIND_PUSH       3'h4
`define KIND_POP        3'h5
`define KIND_VECTOR     3'h6
`define KIND_BRANCH     3'h7

// ****************************************************************
// addressing modes
// ****************************************************************
`define MODE_W                       4
`define MODE_DIRECT                  4'h0
`define MODE_EXTENDED                4'h1
`define MODE_IMMEDIATE               4'h2
`define MODE_INDEX_NO_DISP           4'h3
`define MODE_INDEX_SHORT_DISP        4'h4
`define MODE_INDEX_LONG_DISP         4'h5
`define MODE_INDEX_POSTINC           4'h6
`define MODE_INDEX_DISP_POSTINC      4'h7
`define MODE_STACK_SHORT_DISP        4'h8
`define MODE_STACK_LONG_DISP         4'h9

// ****************************************************************
// fixed pages and reset values
// ****************************************************************
`define VECTOR_PAGE     8'hFF
`define DIRECT_PAGE     8'h00
`define PC_RESET        16'h0000
`define SP_RESET        16'h00FF
`define HX_RESET        16'h0000

`endif

// [src/operand_addr_former.v]
// effective operand address from addressing mode, index, stack pointer and displacement
`timescale 1ns/1ps
`include "cpu_bus_regs.vh"

module operand_addr_former (
  input  wire [3:0]  mode,
  input  wire [15:0] index_val,
  input  wire [15:0] stack_val,
  input  wire [15:0] pc_val,
  input  wire [15:0] disp,
  output reg  [15:0] ea,
  output reg         post_inc
);

  // ****************************************************************
  // address sum per mode
  // ****************************************************************
  // short displacements are unsigned, so only the low byte is added
  always @* begin
    ea       = index_val;
    post_inc = 1'b0;
    case (mode)
      `MODE_DIRECT:             ea = {`DIRECT_PAGE, disp[7:0]};
      `MODE_EXTENDED:           ea = disp;
      `MODE_IMMEDIATE:          ea = pc_val;
      `MODE_INDEX_NO_DISP:      ea = index_val;
      `MODE_INDEX_SHORT_DISP:   ea = index_val + {8'h00, disp[7:0]};
      `MODE_INDEX_LONG_DISP:    ea = index_val + disp;
      `MODE_INDEX_POSTINC: begin
        ea       = index_val;
        post_inc = 1'b1;
      end
      `MODE_INDEX_DISP_POSTINC: begin
        ea       = index_val + {8'h00, disp[7:0]};
        post_inc = 1'b1;
      end
      `MODE_STACK_SHORT_DISP:   ea = stack_val + {8'h00, disp[7:0]};
      `MODE_STACK_LONG_DISP:    ea = stack_val + disp;
      default:                  ea = index_val;
    endcase
  end

endmodule

// [testbench/cpu_bus_props.sv]
// assertion checker watching the bus-cycle sequencer ports
`timescale 1ns/1ps
`include "cpu_bus_regs.vh"
module cpu_bus_props (
  input logic        clk,
  input logic        rst_n,
  input logic        cmd_ready,
  input logic        rsp_valid,
  input logic [7:0]  rsp_data,
  input logic [15:0] bus_addr,
  input logic        bus_rd,
  input logic        bus_wr,
  input logic [2:0]  bus_cycle,
  input logic [15:0] prog_counter,
  input logic [15:0] stack_ptr
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  // ****************************************************************
  // cycle boundaries
  // ****************************************************************
  // any move of the bus outputs marks the start of a new bus cycle
  sequence cyc_start;
    !$stable({bus_addr, bus_rd, bus_wr, bus_cycle});
  endsequence
  // first byte of a vector pair, reached from a different kind
  sequence vec_first;
    bus_cycle == `KIND_VECTOR && $changed(bus_cycle);
  endsequence

  a_one_strobe: assert property (bus_rd != bus_wr)
    else $error("read and write strobes not exclusive");
  a_free_read: assert property (bus_cycle == `KIND_FREE |-> bus_rd && !bus_wr)
    else $error("free cycle not shown as read");
  a_cycle_hold: assert property (cyc_start |=> $stable({bus_addr, bus_rd, bus_wr, bus_cycle})[*8])
    else $error("bus cycle shorter than one bus period");
  a_read_kinds: assert property (bus_cycle inside {`KIND_PROG, `KIND_READ, `KIND_VECTOR} |-> bus_rd)
    else $error("fetch or operand read not a read");
  a_write_kinds: assert property (bus_cycle inside {`KIND_WRITE, `KIND_PUSH} |-> bus_wr && !bus_rd)
    else $error("operand write or push not a write");
  a_push_addr: assert property (cyc_start ##0 bus_cycle == `KIND_PUSH |-> stack_ptr == bus_addr - 16'h0001)
    else $error("push not at stack location");
  a_pop_addr: assert property (cyc_start ##0 bus_cycle == `KIND_POP |-> bus_rd && stack_ptr == bus_addr)
    else $error("pop not at stack location");
  a_vector_page: assert property (bus_cycle == `KIND_VECTOR |-> bus_addr[15:8] == `VECTOR_PAGE)
    else $error("vector read outside top page");
  a_vector_pair: assert property (vec_first |-> ##10 (bus_cycle == `KIND_VECTOR
                                  && bus_addr == $past(bus_addr, 10) + 16'h0001))
    else $error("vector low byte does not follow high byte");
  a_prog_next: assert property (cyc_start ##0 bus_cycle == `KIND_PROG |-> prog_counter == bus_addr + 16'h0001)
    else $error("program fetch not sequential");
  a_ready_pulse: assert property (cmd_ready |=> !cmd_ready[*8])
    else $error("command ready closer than one bus period");
  a_rsp_with_data: assert property ($changed(rsp_data) |-> rsp_valid)
    else $error("response byte moved without a pulse");
endmodule

bind cpu_bus_cycle_addressing cpu_bus_props u_props (
  .clk          (clk),
  .rst_n        (rst_n),
  .cmd_ready    (cmd_ready),
  .rsp_valid    (rsp_valid),
  .rsp_data     (rsp_data),
  .bus_addr     (bus_addr),
  .bus_rd       (bus_rd),
  .bus_wr       (bus_wr),
  .bus_cycle    (bus_cycle),
  .prog_counter (prog_counter),
  .stack_ptr    (stack_ptr)
);

// [testbench/bus_mem_model.sv]
// memory stand-in on the far side of the system bus
`timescale 1ns/1ps
module bus_mem_model (
  input  wire logic        clk,
  input  wire logic [15:0] bus_addr,
  input  wire logic [7:0]  bus_wdata,
  input  wire logic        bus_rd,
  input  wire logic        bus_wr,
  output logic      [7:0]  bus_rdata
);
  logic [7:0] store [logic [15:0]];

  initial bus_rdata = 8'h00;
  // work mid-period, where address and data stand settled; unread data toggles
  always @(negedge clk) begin
    if (bus_wr) begin
      store[bus_addr] = bus_wdata;
      bus_rdata <= ~bus_rdata;
    end
    else if (store.exists(bus_addr)) begin
      bus_rdata <= store[bus_addr];
    end
    else begin
      bus_rdata <= bus_addr[7:0] ^ bus_addr[15:8] ^ 8'h5A;
    end
  end
endmodule

// [testbench/tb.sv]
// self-checking bench for the bus-cycle sequencer
`timescale 1ns/1ps
`include "cpu_bus_regs.vh"
module tb;
  logic        clk, rst_n, cmd_valid, cmd_take, pc_load, sp_load, hx_load;
  logic [2:0]  cmd_kind;
  logic [3:0]  cmd_mode;
  logic [7:0]  cmd_wdata, cmd_vector;
  logic [15:0] pc_load_val, sp_load_val, hx_load_val, pc_m, sp_m, hx_m;
  wire         cmd_ready, rsp_valid, bus_rd, bus_wr;
  wire  [7:0]  rsp_data, bus_wdata, bus_rdata;
  wire  [15:0] bus_addr, prog_counter, stack_ptr, index_reg;
  wire  [2:0]  bus_cycle;
  logic [7:0]  wr_m [logic [15:0]];
  logic [7:0]  rsp_q [$];
  logic [3:0]  m;
  int          n_errors, num_checks, cyc, i;
  logic [31:0] r;

  cpu_bus_cycle_addressing DUT (.clk(clk), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd_kind(cmd_kind), .cmd_mode(cmd_mode), .cmd_wdata(cmd_wdata), .cmd_vector(cmd_vector),
    .cmd_take(cmd_take), .pc_load(pc_load), .pc_load_val(pc_load_val), .sp_load(sp_load),
    .sp_load_val(sp_load_val), .hx_load(hx_load), .hx_load_val(hx_load_val), .rsp_valid(rsp_valid),
    .rsp_data(rsp_data), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_rd(bus_rd), .bus_wr(bus_wr),
    .bus_rdata(bus_rdata), .bus_cycle(bus_cycle), .prog_counter(prog_counter), .stack_ptr(stack_ptr),
    .index_reg(index_reg));
  bus_mem_model mem_u (.clk(clk), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_rd(bus_rd),
    .bus_wr(bus_wr), .bus_rdata(bus_rdata));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ****************************************************************
  // shared tasks
  // ****************************************************************
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic complete_run;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // memory contents as the far side holds them
  function automatic logic [7:0] mem_at(input logic [15:0] a);
    mem_at = wr_m.exists(a) ? wr_m[a] : (a[7:0] ^ a[15:8] ^ 8'h5A);
  endfunction

  // note the expected effect, then offer the command until it is taken
  task automatic issue(input logic [2:0] k, input logic [3:0] md, input logic [7:0] wd, input logic [7:0] v,
                       input logic tk);
    logic [15:0] ea;
    logic [15:0] d;
    int          w;
    w = (md inside {`MODE_EXTENDED, `MODE_INDEX_LONG_DISP, `MODE_STACK_LONG_DISP}) ? 2 :
        (md inside {`MODE_DIRECT, `MODE_INDEX_SHORT_DISP, `MODE_INDEX_DISP_POSTINC, `MODE_STACK_SHORT_DISP}) ? 1 : 0;
    d = 16'h0000;
    case (k)
      `KIND_READ, `KIND_WRITE: begin
        repeat (w) begin
          d = {d[7:0], mem_at(pc_m)};
          pc_m = pc_m + 16'h0001;
        end
        case (md)
          `MODE_DIRECT: ea = {`DIRECT_PAGE, d[7:0]};
          `MODE_EXTENDED: ea = d;
          `MODE_IMMEDIATE: ea = pc_m;
          `MODE_STACK_SHORT_DISP, `MODE_STACK_LONG_DISP: ea = sp_m + d;
          default: ea = hx_m + d;
        endcase
        if (md == `MODE_IMMEDIATE)
          pc_m = pc_m + 16'h0001;
        if (md inside {`MODE_INDEX_POSTINC, `MODE_INDEX_DISP_POSTINC})
          hx_m = hx_m + 16'h0001;
        if (k == `KIND_READ)
          rsp_q.push_back(mem_at(ea));
        else
          wr_m[ea] = wd;
      end
      `KIND_PROG, `KIND_BRANCH: begin
        d = {{8{mem_at(pc_m) > 8'h7F}}, mem_at(pc_m)};
        if (k == `KIND_PROG)
          rsp_q.push_back(d[7:0]);
        pc_m = pc_m + 16'h0001 + ((k == `KIND_BRANCH && tk) ? d : 16'h0000);
      end
      `KIND_PUSH: begin
        wr_m[sp_m] = wd;
        sp_m = sp_m - 16'h0001;
      end
      `KIND_POP: begin
        sp_m = sp_m + 16'h0001;
        rsp_q.push_back(mem_at(sp_m));
      end
      `KIND_VECTOR: begin
        ea = {`VECTOR_PAGE, v};
        pc_m = {mem_at(ea), mem_at(ea + 16'h0001)};
        rsp_q.push_back(pc_m[7:0]);
      end
      default: ;
    endcase
    @(negedge clk);
    {cmd_kind, cmd_mode, cmd_wdata, cmd_vector, cmd_take} = {k, md, wd, v, tk};
    cmd_valid = 1'b1;
    w = 0;
    while (cmd_ready !== 1'b1 && w < 100) begin
      @(negedge clk);
      w++;
    end
    check(w < 100, 1'b1);
    @(posedge clk);
  endtask

  // let the pipeline drain, then compare the architectural registers
  task automatic settle;
    @(negedge clk);
    cmd_valid = 1'b0;
    repeat (60) @(negedge clk);
    check(prog_counter, pc_m);
    check(stack_ptr, sp_m);
    check(index_reg, hx_m);
    check(rsp_q.size(), 16'h0000);
  endtask

  task automatic load_regs;
    @(negedge clk);
    {pc_load, sp_load, hx_load} = 3'h7;
    pc_load_val = 16'($urandom);
    sp_load_val = 16'($urandom);
    hx_load_val = 16'($urandom);
    {pc_m, sp_m, hx_m} = {pc_load_val, sp_load_val, hx_load_val};
    @(negedge clk);
    {pc_load, sp_load, hx_load} = 3'h0;
  endtask

  task automatic reset_dut;
    @(negedge clk);
    {rst_n, cmd_valid} = 2'b00;
    repeat (20) @(negedge clk);
    check({11'h000, bus_rd, bus_wr, bus_cycle}, 16'h0010);
    check(bus_addr, 16'h0000);
    check(prog_counter, `PC_RESET);
    check(stack_ptr, `SP_RESET);
    check(index_reg, `HX_RESET);
    rsp_q.delete();
    {pc_m, sp_m, hx_m} = {`PC_RESET, `SP_RESET, `HX_RESET};
    rst_n = 1'b1;
  endtask

  // ****************************************************************
  // response watcher and hang guard
  // ****************************************************************
  always @(negedge clk) begin
    if (rst_n && rsp_valid === 1'b1) begin
      if (rsp_q.size() == 0)
        check(rsp_data, 16'hFFFF);
      else
        check(rsp_data, rsp_q.pop_front());
    end
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      n_errors++;
      complete_run;
    end
  end

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    {rst_n, cmd_valid, cmd_kind, cmd_mode, cmd_wdata, cmd_vector, cmd_take} = '0;
    {pc_load, sp_load, hx_load, pc_load_val, sp_load_val, hx_load_val} = '0;
    {n_errors, num_checks, cyc} = '0;
    r = $urandom(32'h5362);
    reset_dut;
    // every addressing mode, read then write (the immediate write goes as direct), back to back from random registers
    load_regs;
    for (i = 0; i < 10; i++) begin
      issue(`KIND_READ, 4'(i), 8'h00, 8'h00, 1'b0);
      m = (i == 2) ? `MODE_DIRECT : 4'(i);
      issue(`KIND_WRITE, m, 8'($urandom), 8'h00, 1'b0);
    end
    settle;
    // stack round trip, fetches, free slot, branches and vectors
    for (i = 0; i < 3; i++)
      issue(`KIND_PUSH, 4'h0, 8'hC0 + 8'(i), 8'h00, 1'b0);
    for (i = 0; i < 3; i++)
      issue(`KIND_POP, 4'h0, 8'h00, 8'h00, 1'b0);
    issue(`KIND_PROG, 4'h0, 8'h00, 8'h00, 1'b0);
    issue(`KIND_PROG, 4'h0, 8'h00, 8'h00, 1'b0);
    issue(`KIND_FREE, 4'h0, 8'h00, 8'h00, 1'b0);
    issue(`KIND_BRANCH, 4'h0, 8'h00, 8'h00, 1'b1);
    issue(`KIND_BRANCH, 4'h0, 8'h00, 8'h00, 1'b0);
    issue(`KIND_VECTOR, 4'h0, 8'h00, 8'hFE, 1'b0);
    issue(`KIND_VECTOR, 4'h0, 8'h00, 8'h00, 1'b0);
    settle;
    // random mix with fresh register loads
    for (i = 0; i < 80; i++) begin
      if (i % 16 == 15) begin
        settle;
        load_regs;
      end
      r = $urandom;
      m = 4'(r[7:4] % 10);
      if (r[2:0] == `KIND_WRITE && m == `MODE_IMMEDIATE)
        m = `MODE_DIRECT;
      issue(r[2:0], m, r[15:8], 8'(r[31:16] % 255), r[3]);
    end
    settle;
    // reset in the middle of a long-displacement read
    issue(`KIND_READ, `MODE_INDEX_LONG_DISP, 8'h00, 8'h00, 1'b0);
    reset_dut;
    issue(`KIND_PROG, 4'h0, 8'h00, 8'h00, 1'b0);
    settle;
    foreach (wr_m[a])
      check(mem_u.store[a], wr_m[a]);
    complete_run;
  end
endmodule
